// File: rtl/pldc_cell.sv
// Programmable logic cell: two sum-of-products arrays and an 8-bit datapath
`timescale 1ns/1ps
module pldc_cell #(
	parameter int DW = pldc_pkg::DW,
	parameter int PLD_NUM = pldc_pkg::PLD_NUM
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [PLD_NUM-1:0][pldc_pkg::PLD_IN-1:0] pld_in,
	input wire pldc_pkg::pldc_pld_cfg_type [PLD_NUM-1:0] pld_cfg,
	output logic [PLD_NUM-1:0][pldc_pkg::PLD_OUT-1:0] pld_out,
	input wire logic [pldc_pkg::CS_AW-1:0] cs_addr,
	input wire logic cs_wr_en,
	input wire logic [pldc_pkg::CS_AW-1:0] cs_wr_addr,
	input wire logic [pldc_pkg::CS_W-1:0] cs_wr_data,
	input wire logic [DW-1:0] mask_cfg,
	input wire logic [1:0] fifo_dir,
	input wire pldc_pkg::pldc_bus_type bus_req,
	output logic [DW-1:0] bus_rdata,
	output logic [1:0] fifo_empty,
	output logic [1:0] fifo_full,
	output pldc_pkg::pldc_cond_type cond
);

	// ------------------------------------------------------------
	// Sum-of-products arrays
	// ------------------------------------------------------------
	// Output stage is always a flip-flop: combinational mode shows
	// the sum after one edge, registered mode adds the macrocell edge
	genvar g, p;
	generate
		for (g = 0; g < PLD_NUM; g++) begin : g_pld
			logic [pldc_pkg::PLD_PT-1:0] term;
			logic [pldc_pkg::PLD_OUT-1:0] sop;
			logic [pldc_pkg::PLD_OUT-1:0] cell_ff;
			for (p = 0; p < pldc_pkg::PLD_PT; p++) begin : g_term
				// Unused inputs drop out of the AND
				assign term[p] = &(~pld_cfg[g].use_in[p] |
					(pld_in[g] ^ pld_cfg[g].inv_in[p]));
			end
			for (p = 0; p < pldc_pkg::PLD_OUT; p++) begin : g_sum
				assign sop[p] = |(pld_cfg[g].or_sel[p] & term);
			end
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					cell_ff <= '0;
					pld_out[g] <= '0;
				end else begin
					cell_ff <= sop;
					pld_out[g] <= (pld_cfg[g].reg_sel & cell_ff) |
						(~pld_cfg[g].reg_sel & sop);
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Control store
	// ------------------------------------------------------------
	logic [pldc_pkg::CS_W-1:0] cs_word;
	pldc_pkg::pldc_cfg_type cfg;

	pldc_store u_store (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.wr_en(cs_wr_en),
		.wr_addr(cs_wr_addr),
		.wr_data(cs_wr_data),
		.rd_addr(cs_addr),
		.rd_data(cs_word)
	);

	// Word addressed in one cycle steers the datapath in the next
	assign cfg = pldc_pkg::pldc_cfg_type'(cs_word);

	// ------------------------------------------------------------
	// Working registers
	// ------------------------------------------------------------
	logic [DW-1:0] acc_ff [2];
	logic [DW-1:0] dat_ff [2];
	logic [DW-1:0] fifo_head [2];
	logic [1:0] fifo_ok;

	// ------------------------------------------------------------
	// ALU
	// ------------------------------------------------------------
	logic [DW-1:0] op_a;
	logic [DW-1:0] op_b;
	logic [DW-1:0] alu_raw;
	logic [DW-1:0] alu_sh;
	logic [DW-1:0] alu_out;
	logic alu_ovf;

	assign op_a = cfg.srca ? acc_ff[1] : acc_ff[0];
	assign op_b = (cfg.srcb == pldc_pkg::SRCB_ACC0) ? acc_ff[0] :
		(cfg.srcb == pldc_pkg::SRCB_ACC1) ? acc_ff[1] :
		(cfg.srcb == pldc_pkg::SRCB_DAT0) ? dat_ff[0] :
		dat_ff[1];

	always_comb begin
		alu_raw = op_a;
		alu_ovf = 1'b0;
		case (cfg.func)
			pldc_pkg::ALU_INC: begin
				alu_raw = op_a + pldc_pkg::BYTE_ONE;
				alu_ovf = (op_a == pldc_pkg::BYTE_MAXPOS);
			end
			pldc_pkg::ALU_DEC: begin
				alu_raw = op_a - pldc_pkg::BYTE_ONE;
				alu_ovf = (op_a == pldc_pkg::BYTE_MINNEG);
			end
			pldc_pkg::ALU_ADD: begin
				alu_raw = op_a + op_b;
				alu_ovf = (op_a[DW-1] == op_b[DW-1]) &&
					(alu_raw[DW-1] != op_a[DW-1]);
			end
			pldc_pkg::ALU_SUB: begin
				alu_raw = op_a - op_b;
				alu_ovf = (op_a[DW-1] != op_b[DW-1]) &&
					(alu_raw[DW-1] != op_a[DW-1]);
			end
			pldc_pkg::ALU_AND: alu_raw = op_a & op_b;
			pldc_pkg::ALU_OR: alu_raw = op_a | op_b;
			pldc_pkg::ALU_XOR: alu_raw = op_a ^ op_b;
			pldc_pkg::ALU_PASS: alu_raw = op_a;
			default: alu_raw = op_a;
		endcase
	end

	// Shift and mask follow any function
	assign alu_sh = (cfg.shift == pldc_pkg::SH_LEFT) ?
		{alu_raw[DW-2:0], 1'b0} :
		(cfg.shift == pldc_pkg::SH_RIGHT) ? {1'b0, alu_raw[DW-1:1]} :
		(cfg.shift == pldc_pkg::SH_SWAP) ?
		{alu_raw[DW/2-1:0], alu_raw[DW-1:DW/2]} : alu_raw;
	assign alu_out = cfg.mask_en ? (alu_sh | mask_cfg) : alu_sh;

	// ------------------------------------------------------------
	// Registers and FIFOs, one slice per index
	// ------------------------------------------------------------
	// Datapath writes win over a bus write in the same cycle
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_slice
			logic [DW-1:0] mem_ff [pldc_pkg::FIFO_DEPTH];
			logic [pldc_pkg::FIFO_PW-1:0] wp_ff;
			logic [pldc_pkg::FIFO_PW-1:0] rp_ff;
			logic [pldc_pkg::FIFO_CW-1:0] cnt_ff;
			logic [pldc_pkg::FIFO_CW-1:0] nxt_cnt;
			logic [DW-1:0] nxt_acc;
			logic [DW-1:0] nxt_dat;
			logic [DW-1:0] push_data;
			logic is_out;
			logic hit_acc;
			logic hit_dat;
			logic hit_fifo;
			logic full;
			logic empty;
			logic push;
			logic pop;
			logic push_ok;
			logic pop_ok;
			logic take_acc;
			logic take_dat;

			assign is_out = (fifo_dir[i] == pldc_pkg::FIFO_AS_OUTPUT);
			assign hit_acc = (bus_req.addr == 3'(pldc_pkg::ADDR_ACC0 + i));
			assign hit_dat = (bus_req.addr == 3'(pldc_pkg::ADDR_DAT0 + i));
			assign hit_fifo = (bus_req.addr ==
				3'(pldc_pkg::ADDR_FIFO0 + i));
			assign full = (cnt_ff == pldc_pkg::CNT_FULL);
			assign empty = (cnt_ff == pldc_pkg::CNT_ZERO);

			// Direction decides who fills and who drains
			assign push = is_out ? cfg.fifo_op[i] :
				(bus_req.wr & hit_fifo);
			assign pop = is_out ? (bus_req.rd & hit_fifo) :
				cfg.fifo_op[i];
			// A full write or empty read leaves the contents alone
			assign push_ok = push & ~full;
			assign pop_ok = pop & ~empty;
			assign push_data = ~is_out ? bus_req.wdata :
				cfg.fifo_take_alu ? alu_out : acc_ff[i];
			assign fifo_head[i] = mem_ff[rp_ff];
			assign fifo_ok[i] = ~is_out & cfg.fifo_op[i] & ~empty;

			assign nxt_cnt = cnt_ff + (push_ok ? pldc_pkg::CNT_ONE :
				pldc_pkg::CNT_ZERO) - (pop_ok ? pldc_pkg::CNT_ONE :
				pldc_pkg::CNT_ZERO);

			// Loads from a FIFO need a byte waiting in it
			assign take_acc = cfg.acc_from_fifo & fifo_ok[i];
			assign take_dat = cfg.dat_from_fifo & fifo_ok[i];
			assign nxt_acc = cfg.acc_we[i] ?
				(take_acc ? fifo_head[i] : alu_out) :
				(bus_req.wr & hit_acc) ? bus_req.wdata :
				acc_ff[i];
			assign nxt_dat = take_dat ? fifo_head[i] :
				(bus_req.wr & hit_dat) ? bus_req.wdata :
				dat_ff[i];

			always_ff @(posedge sys_clk) begin
				if (push_ok) begin
					mem_ff[wp_ff] <= push_data;
				end
			end

			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					acc_ff[i] <= pldc_pkg::BYTE_ZERO;
					dat_ff[i] <= pldc_pkg::BYTE_ZERO;
					wp_ff <= pldc_pkg::PTR_ZERO;
					rp_ff <= pldc_pkg::PTR_ZERO;
					cnt_ff <= pldc_pkg::CNT_ZERO;
					fifo_empty[i] <= 1'b1;
					fifo_full[i] <= 1'b0;
				end else begin
					acc_ff[i] <= nxt_acc;
					dat_ff[i] <= nxt_dat;
					wp_ff <= push_ok ? wp_ff + pldc_pkg::PTR_ONE : wp_ff;
					rp_ff <= pop_ok ? rp_ff + pldc_pkg::PTR_ONE : rp_ff;
					cnt_ff <= nxt_cnt;
					fifo_empty[i] <= (nxt_cnt == pldc_pkg::CNT_ZERO);
					fifo_full[i] <= (nxt_cnt == pldc_pkg::CNT_FULL);
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Conditions
	// ------------------------------------------------------------
	// Flags follow the register values one edge later; ovf follows the ALU overflow of the current word
	pldc_pkg::pldc_cond_type nxt_cond;

	assign nxt_cond.cmp_eq = {acc_ff[1] == dat_ff[1],
		acc_ff[0] == dat_ff[0]};
	assign nxt_cond.cmp_lt = {acc_ff[1] < dat_ff[1],
		acc_ff[0] < dat_ff[0]};
	assign nxt_cond.zero = {acc_ff[1] == pldc_pkg::BYTE_ZERO,
		acc_ff[0] == pldc_pkg::BYTE_ZERO};
	assign nxt_cond.ones = {acc_ff[1] == pldc_pkg::BYTE_ONES,
		acc_ff[0] == pldc_pkg::BYTE_ONES};
	assign nxt_cond.ovf = alu_ovf;

	// ------------------------------------------------------------
	// Bus read path
	// ------------------------------------------------------------
	logic [DW-1:0] rd_mux;

	assign rd_mux = (bus_req.addr == pldc_pkg::ADDR_ACC0) ? acc_ff[0] :
		(bus_req.addr == 3'(pldc_pkg::ADDR_ACC0 + 1)) ? acc_ff[1] :
		(bus_req.addr == pldc_pkg::ADDR_DAT0) ? dat_ff[0] :
		(bus_req.addr == 3'(pldc_pkg::ADDR_DAT0 + 1)) ? dat_ff[1] :
		(bus_req.addr == pldc_pkg::ADDR_FIFO0) ? fifo_head[0] :
		(bus_req.addr == 3'(pldc_pkg::ADDR_FIFO0 + 1)) ? fifo_head[1] :
		pldc_pkg::BYTE_ZERO;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bus_rdata <= pldc_pkg::BYTE_ZERO;
			cond <= '0;
		end else begin
			bus_rdata <= bus_req.rd ? rd_mux : bus_rdata;
			cond <= nxt_cond;
		end
	end

endmodule : pldc_cell

// File: inc/pldc_pkg.sv
// Shared constants, encodings and carrier types for the logic datapath cell
package pldc_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int DW = 8;
	localparam int PLD_IN = 12;
	localparam int PLD_PT = 8;
	localparam int PLD_OUT = 4;
	localparam int PLD_NUM = 2;
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_PW = 2;
	localparam int FIFO_CW = 3;
	localparam int CS_WORDS = 8;
	localparam int CS_AW = 3;
	localparam int CS_W = 16;
	localparam int BUS_AW = 3;

	// ------------------------------------------------------------
	// Bus address map of the working registers
	// ------------------------------------------------------------
	localparam logic [2:0] ADDR_ACC0 = 3'h0;
	localparam logic [2:0] ADDR_DAT0 = 3'h2;
	localparam logic [2:0] ADDR_FIFO0 = 3'h4;

	// ------------------------------------------------------------
	// Reset values and fixed values
	// ------------------------------------------------------------
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_MAXPOS = 8'h7f;
	localparam logic [7:0] BYTE_MINNEG = 8'h80;
	localparam logic [1:0] PTR_ZERO = 2'h0;
	localparam logic [1:0] PTR_ONE = 2'h1;
	localparam logic [2:0] CNT_ZERO = 3'h0;
	localparam logic [2:0] CNT_ONE = 3'h1;
	localparam logic [2:0] CNT_FULL = 3'h4;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic FIFO_AS_INPUT = 1'b0;
	localparam logic FIFO_AS_OUTPUT = 1'b1;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ALU_INC = 3'b000,
		ALU_DEC = 3'b001,
		ALU_ADD = 3'b010,
		ALU_SUB = 3'b011,
		ALU_AND = 3'b100,
		ALU_OR = 3'b101,
		ALU_XOR = 3'b110,
		ALU_PASS = 3'b111
	} pldc_alu_type;

	typedef enum logic [1:0] {
		SH_NONE = 2'b00,
		SH_LEFT = 2'b01,
		SH_RIGHT = 2'b10,
		SH_SWAP = 2'b11
	} pldc_shift_type;

	typedef enum logic [1:0] {
		SRCB_ACC0 = 2'b00,
		SRCB_ACC1 = 2'b01,
		SRCB_DAT0 = 2'b10,
		SRCB_DAT1 = 2'b11
	} pldc_srcb_type;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	// One 16-bit control store word
	typedef struct packed {
		logic dat_from_fifo;
		logic fifo_take_alu;
		logic [1:0] fifo_op;
		logic acc_from_fifo;
		logic [1:0] acc_we;
		logic mask_en;
		pldc_shift_type shift;
		pldc_srcb_type srcb;
		logic srca;
		pldc_alu_type func;
	} pldc_cfg_type;

	typedef struct packed {
		logic [PLD_PT-1:0][PLD_IN-1:0] use_in;
		logic [PLD_PT-1:0][PLD_IN-1:0] inv_in;
		logic [PLD_OUT-1:0][PLD_PT-1:0] or_sel;
		logic [PLD_OUT-1:0] reg_sel;
	} pldc_pld_cfg_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [BUS_AW-1:0] addr;
		logic [DW-1:0] wdata;
	} pldc_bus_type;

	typedef struct packed {
		logic [1:0] cmp_eq;
		logic [1:0] cmp_lt;
		logic [1:0] zero;
		logic [1:0] ones;
		logic ovf;
	} pldc_cond_type;

endpackage : pldc_pkg

// File: rtl/pldc_store.sv
// Control store memory with a registered read port
`timescale 1ns/1ps
module pldc_store #(
	parameter int WORDS = pldc_pkg::CS_WORDS,
	parameter int AW = pldc_pkg::CS_AW,
	parameter int W = pldc_pkg::CS_W
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [W-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [W-1:0] rd_data
);

	logic [W-1:0] mem [WORDS];

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// Array is left without reset so it maps onto plain RAM
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// ------------------------------------------------------------
	// Read
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_data <= pldc_pkg::WORD_ZERO;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule : pldc_store

// File: tb/pldc_cell_chk.sv
// Port assertions for the logic datapath cell
`timescale 1ns/1ps
module pldc_cell_chk #(
	parameter int DW = pldc_pkg::DW,
	parameter int PLD_NUM = pldc_pkg::PLD_NUM
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [PLD_NUM-1:0][pldc_pkg::PLD_IN-1:0] pld_in,
	input wire pldc_pkg::pldc_pld_cfg_type [PLD_NUM-1:0] pld_cfg,
	input wire logic [PLD_NUM-1:0][pldc_pkg::PLD_OUT-1:0] pld_out,
	input wire logic [pldc_pkg::CS_AW-1:0] cs_addr,
	input wire logic cs_wr_en,
	input wire logic [pldc_pkg::CS_AW-1:0] cs_wr_addr,
	input wire logic [pldc_pkg::CS_W-1:0] cs_wr_data,
	input wire logic [DW-1:0] mask_cfg,
	input wire logic [1:0] fifo_dir,
	input wire pldc_pkg::pldc_bus_type bus_req,
	input wire logic [DW-1:0] bus_rdata,
	input wire logic [1:0] fifo_empty,
	input wire logic [1:0] fifo_full,
	input wire pldc_pkg::pldc_cond_type cond
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire logic wr0 = bus_req.wr && bus_req.addr == 3'h4;
	wire logic rd1 = bus_req.rd && bus_req.addr == 3'h5;
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_reset_status: assert property ($rose(nrst) |->
		fifo_empty == 2'b11 && fifo_full == 2'b00 && bus_rdata == 8'h00)
		else $error("status not at reset value");
	a_empty_full_excl: assert property ((fifo_empty & fifo_full) == 2'b00)
		else $error("fifo empty and full together");
	a_in_push: assert property (!fifo_dir[0] && !fifo_full[0] && wr0
		|=> !fifo_empty[0]) else $error("bus push lost");
	a_in_stays_empty: assert property (!fifo_dir[0] && fifo_empty[0] && !wr0
		|=> fifo_empty[0]) else $error("input fifo filled by itself");
	a_out_stays_full: assert property (fifo_dir[1] && fifo_full[1] && !rd1
		|=> fifo_full[1]) else $error("output fifo lost entry");
	a_unmapped_read: assert property (bus_req.rd && bus_req.addr[2:1] == 2'b11
		|=> bus_rdata == 8'h00) else $error("unmapped read not zero");
	a_rdata_hold: assert property (!bus_req.rd |=> $stable(bus_rdata))
		else $error("read data moved without read");
	a_zero_ones: assert property ((cond.zero & cond.ones) == 2'b00)
		else $error("zero and ones together");
	a_eq_lt: assert property ((cond.cmp_eq & cond.cmp_lt) == 2'b00)
		else $error("equal and less together");
	// Empty sum must read low in either output mode
	a_empty_sum: assert property ((pld_cfg[0].or_sel[0] == 8'h00)[*3]
		|-> !pld_out[0][0]) else $error("empty sum not low");
	cover property (fifo_full[0]);
	cover property (cond.zero[0]);
	cover property (rd1);
endmodule : pldc_cell_chk

bind pldc_cell pldc_cell_chk #(.DW(DW), .PLD_NUM(PLD_NUM)) pldc_cell_chk_inst (
	.sys_clk(sys_clk), .nrst(nrst), .pld_in(pld_in), .pld_cfg(pld_cfg),
	.pld_out(pld_out), .cs_addr(cs_addr), .cs_wr_en(cs_wr_en),
	.cs_wr_addr(cs_wr_addr), .cs_wr_data(cs_wr_data), .mask_cfg(mask_cfg),
	.fifo_dir(fifo_dir), .bus_req(bus_req), .bus_rdata(bus_rdata),
	.fifo_empty(fifo_empty), .fifo_full(fifo_full), .cond(cond));

// File: tb/pldc_bus_bfm.sv
// System bus master model for the working registers and FIFOs
`timescale 1ns/1ps
module pldc_bus_bfm (
	input wire logic sys_clk,
	input wire logic [1:0] fifo_dir,
	input wire logic [1:0] fifo_empty,
	input wire logic [1:0] fifo_full,
	input wire logic [7:0] bus_rdata,
	output pldc_pkg::pldc_bus_type bus_req
);
	initial bus_req = '0;
	// One access; released data is inverted so stale bytes never pass
	task automatic acc(input logic rd, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		logic s;
		#1;
		s = a[2:1] == 2'b10 && (rd ? fifo_dir[a[0]] && fifo_empty[a[0]] :
			!fifo_dir[a[0]] && fifo_full[a[0]]);
		if (!s) begin
			@(posedge sys_clk);
			bus_req <= '{wr: !rd, rd: rd, addr: a, wdata: d};
			@(posedge sys_clk);
			bus_req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: ~d};
			@(posedge sys_clk);
		end
		q = bus_rdata;
	endtask : acc
endmodule : pldc_bus_bfm

// File: tb/pldc_cell_tb_top.sv
// Self-checking bench for the logic datapath cell
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module pldc_cell_tb_top;
	typedef struct packed {
		logic [15:0] w;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] e;
	} pldc_row_type;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0][11:0] pld_in = '0;
	pldc_pkg::pldc_pld_cfg_type [1:0] pld_cfg = '0;
	logic [1:0][3:0] pld_out;
	logic [2:0] cs_addr = 3'h0;
	logic cs_wr_en = 1'b0;
	logic [2:0] cs_wr_addr = 3'h0;
	logic [15:0] cs_wr_data = 16'h0000;
	pldc_pkg::pldc_bus_type bus_req;
	logic [7:0] bus_rdata;
	logic [7:0] q;
	logic [1:0] fifo_empty;
	logic [1:0] fifo_full;
	pldc_pkg::pldc_cond_type cond;
	int failures = 0;
	int n_checks = 0;
	// Word: acc0 written, B from data0; shift and mask rows use pass
	pldc_row_type rows [12] = '{
		'{16'h0220, 8'h7f, 8'h00, 8'h80}, '{16'h0221, 8'h00, 8'h00, 8'hff},
		'{16'h0222, 8'hf0, 8'h0f, 8'hff}, '{16'h0223, 8'h55, 8'h55, 8'h00},
		'{16'h0224, 8'hcc, 8'haa, 8'h88}, '{16'h0225, 8'hcc, 8'haa, 8'hee},
		'{16'h0226, 8'hcc, 8'haa, 8'h66}, '{16'h0227, 8'h12, 8'h12, 8'h12},
		'{16'h0267, 8'h81, 8'h00, 8'h02}, '{16'h02a7, 8'h81, 8'h00, 8'h40},
		'{16'h02e7, 8'h12, 8'h00, 8'h21}, '{16'h0327, 8'h10, 8'h00, 8'h13}};
	initial forever #2 sys_clk = ~sys_clk;
	pldc_cell pldc_cell_inst (.sys_clk(sys_clk), .nrst(nrst), .pld_in(pld_in),
		.pld_cfg(pld_cfg), .pld_out(pld_out), .cs_addr(cs_addr),
		.cs_wr_en(cs_wr_en), .cs_wr_addr(cs_wr_addr), .cs_wr_data(cs_wr_data),
		.mask_cfg(8'h03), .fifo_dir(2'b10), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .fifo_empty(fifo_empty), .fifo_full(fifo_full),
		.cond(cond));
	pldc_bus_bfm pldc_bus_bfm_inst (.sys_clk(sys_clk), .fifo_dir(2'b10),
		.fifo_empty(fifo_empty), .fifo_full(fifo_full), .bus_rdata(bus_rdata),
		.bus_req(bus_req));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic bw(input logic [2:0] a, input logic [7:0] d);
		pldc_bus_bfm_inst.acc(1'b0, a, d, q);
	endtask : bw
	task automatic br(input logic [2:0] a);
		pldc_bus_bfm_inst.acc(1'b1, a, 8'h00, q);
	endtask : br
	task automatic cs_load(input logic [2:0] a, input logic [15:0] w);
		@(posedge sys_clk);
		cs_wr_en <= 1'b1;
		cs_wr_addr <= a;
		cs_wr_data <= w;
		@(posedge sys_clk);
		cs_wr_en <= 1'b0;
	endtask : cs_load
	// Word 0 stays all zero, so idle cycles write nothing
	task automatic run(input logic [2:0] a);
		@(posedge sys_clk);
		cs_addr <= a;
		@(posedge sys_clk);
		cs_addr <= 3'h0;
		repeat (3) @(posedge sys_clk);
	endtask : run
	task automatic do_reset();
		nrst <= 1'b0;
		repeat (8) @(posedge sys_clk);
		`CHK(fifo_empty, 2'b11)
		`CHK({fifo_full, bus_rdata, cond, pld_out}, 27'h000_0000)
		nrst <= 1'b1;
	endtask : do_reset
	task automatic settle();
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : settle
	task automatic close_out();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		close_out();
	end
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		do_reset();
		for (int i = 0; i < 8; i++) cs_load(3'(i), 16'h0000);
		foreach (rows[i]) begin
			bw(3'h0, rows[i].a);
			bw(3'h2, rows[i].b);
			cs_load(3'h1, rows[i].w);
			run(3'h1);
			br(3'h0);
			`CHK(q, rows[i].e)
			`CHK(cond.zero[0], rows[i].e == 8'h00)
			`CHK(cond.ones[0], rows[i].e == 8'hff)
			`CHK(cond.cmp_eq[0], rows[i].e == rows[i].b)
			`CHK(cond.cmp_lt[0], rows[i].e < rows[i].b)
		end
		// Idle word 0 also runs INC on acc0, so overflow stays high until the operation moves acc0 off 7f
		bw(3'h0, 8'h7f);
		cs_load(3'h1, 16'h0220);
		@(posedge sys_clk);
		cs_addr <= 3'h1;
		@(posedge sys_clk);
		cs_addr <= 3'h0;
		@(posedge sys_clk);
		#1;
		`CHK(cond.ovf, 1'b1)
		@(posedge sys_clk);
		#1;
		`CHK(cond.ovf, 1'b0)
		for (int i = 0; i < 5; i++) bw(3'h4, 8'(8'h11 * (i + 1)));
		`CHK(fifo_full, 2'b01)
		cs_load(3'h2, 16'h9000);
		for (int i = 0; i < 4; i++) begin
			run(3'h2);
			br(3'h2);
			`CHK(q, 8'(8'h11 * (i + 1)))
		end
		`CHK(fifo_empty[0], 1'b1)
		bw(3'h1, 8'h5a);
		cs_load(3'h3, 16'h2000);
		run(3'h3);
		`CHK(fifo_empty[1], 1'b0)
		br(3'h5);
		`CHK(q, 8'h5a)
		bw(3'h5, 8'h77);
		`CHK(fifo_empty[1], 1'b1)
		bw(3'h6, 8'h99);
		br(3'h6);
		`CHK(q, 8'h00)
		pld_cfg[0].use_in[0][0] <= 1'b1;
		pld_cfg[0].or_sel[0] <= 8'h01;
		pld_in[0][0] <= 1'b1;
		settle();
		`CHK(pld_out[0][0], 1'b1)
		pld_cfg[0].inv_in[0][0] <= 1'b1;
		settle();
		`CHK(pld_out[0][0], 1'b0)
		pld_cfg[0].inv_in[0][0] <= 1'b0;
		pld_cfg[0].reg_sel[0] <= 1'b1;
		settle();
		`CHK(pld_out[0][0], 1'b1)
		do_reset();
		close_out();
	end
endmodule : pldc_cell_tb_top
